// >>> hw/pwq_channel.sv
// Pulse-width channel with APB registers and deferred update path
// Operation
// - Update write at counter 0/1 applies immediately
// - Period updates ignored while period is zero
// - Left mode: first period from 0, later from 1
// - Zero duty gives a flat output level
// - Early disable stops output, flag stays set
//
// The address map and register access over APB were chosen for this implementation.
module pwq_channel (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pwm_out
);
  localparam int W = pwq_pkg::CNT_W;

  pwq_pkg::pwq_state_type s_r;
  pwq_pkg::pwq_state_type s_nxt;

  logic                       acc;
  logic                       wr;
  logic                       upd_wr;
  logic                       en_wr;
  logic                       dis_wr;
  logic                       tick;
  logic                       period_end;
  logic                       imm_ok;
  logic [pwq_pkg::PRESC_W-1:0] presc_lim;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == pwq_pkg::OFS_ENABLE) || (a == pwq_pkg::OFS_DISABLE) ||
                (a == pwq_pkg::OFS_STATUS) || (a == pwq_pkg::OFS_MODE) ||
                (a == pwq_pkg::OFS_DUTY) || (a == pwq_pkg::OFS_PERIOD) ||
                (a == pwq_pkg::OFS_COUNTER) || (a == pwq_pkg::OFS_UPDATE);
  endfunction

  function automatic logic [31:0] read_word(input pwq_pkg::pwq_state_type s,
                                            input logic [7:0] a);
    logic [31:0] d;
    d = 32'h00000000;
    case (a)
      pwq_pkg::OFS_STATUS: begin
        d[pwq_pkg::STS_ACTIVE_BIT]  = s.active_flag;
        d[pwq_pkg::STS_ENABLED_BIT] = s.enabled;
        d[pwq_pkg::STS_PEND_BIT]    = s.pend_valid;
      end
      pwq_pkg::OFS_MODE: begin
        d[pwq_pkg::MODE_POL_BIT]     = s.pol;
        d[pwq_pkg::MODE_UPD_PER_BIT] = s.upd_period;
        d[pwq_pkg::MODE_CENTER_BIT]  = s.center;
        d[pwq_pkg::MODE_PRE_LSB +: pwq_pkg::PRE_W] = s.pre;
      end
      pwq_pkg::OFS_DUTY:    d[W-1:0] = s.duty;
      pwq_pkg::OFS_PERIOD:  d[W-1:0] = s.period;
      pwq_pkg::OFS_COUNTER: d[W-1:0] = s.counter;
      pwq_pkg::OFS_UPDATE:  d[W-1:0] = s.pend_val;
      default:              d = 32'h00000000;
    endcase
    read_word = d;
  endfunction

  // Access phase completes in the cycle our registered pready is high
  assign acc       = psel && penable && s_r.rsp.pready;
  assign wr        = acc && pwrite;
  assign upd_wr    = wr && (paddr == pwq_pkg::OFS_UPDATE);
  assign en_wr     = wr && (paddr == pwq_pkg::OFS_ENABLE) && pwdata[pwq_pkg::CMD_BIT];
  assign dis_wr    = wr && (paddr == pwq_pkg::OFS_DISABLE) && pwdata[pwq_pkg::CMD_BIT];
  assign presc_lim = pwq_pkg::PRESC_W'((16'h0001 << s_r.pre) - 16'h0001);
  // Lowered prescale while running never strands the divider
  assign tick      = s_r.enabled && (s_r.presc >= presc_lim);
  // Zero period never ends a period, so pending period values wait
  assign period_end = tick && (s_r.period != '0) &&
                      (s_r.center ? (s_r.count_down && s_r.counter <= pwq_pkg::CNT_LATER)
                                  : (s_r.counter >= s_r.period));
  assign imm_ok    = (s_r.counter <= pwq_pkg::CNT_IMM_MAX) &&
                     !(s_r.upd_period && s_r.period == '0);

  always_comb begin
    s_nxt = s_r;
    if (s_r.enabled) begin
      s_nxt.presc = tick ? '0 : pwq_pkg::PRESC_W'(s_r.presc + 1'b1);
    end
    if (tick) begin
      s_nxt.aged = 1'b1;
      if (s_r.period == '0) begin
        s_nxt.counter = '0;
      end else if (s_r.center) begin
        if (s_r.count_down) begin
          if (s_r.counter <= pwq_pkg::CNT_LATER) begin
            s_nxt.counter    = '0;
            s_nxt.count_down = 1'b0;
          end else begin
            s_nxt.counter = W'(s_r.counter - 1'b1);
          end
        end else if (s_r.counter >= s_r.period) begin
          s_nxt.count_down = 1'b1;
          s_nxt.counter    = W'(s_r.counter - 1'b1);
        end else begin
          s_nxt.counter = W'(s_r.counter + 1'b1);
        end
      end else if (period_end) begin
        s_nxt.counter      = pwq_pkg::CNT_LATER;
        s_nxt.first_period = 1'b0;
      end else begin
        s_nxt.counter = W'(s_r.counter + 1'b1);
      end
    end
    // pending value lands at the period boundary
    if (period_end && s_r.pend_valid) begin
      s_nxt.pend_valid = 1'b0;
      if (s_r.pend_is_period) begin
        s_nxt.period = s_r.pend_val;
      end else begin
        s_nxt.duty = s_r.pend_val;
      end
    end
    if (wr) begin
      case (paddr)
        pwq_pkg::OFS_MODE: begin
          s_nxt.pol        = pwdata[pwq_pkg::MODE_POL_BIT];
          s_nxt.upd_period = pwdata[pwq_pkg::MODE_UPD_PER_BIT];
          s_nxt.center     = pwdata[pwq_pkg::MODE_CENTER_BIT];
          s_nxt.pre        = pwdata[pwq_pkg::MODE_PRE_LSB +: pwq_pkg::PRE_W];
        end
        pwq_pkg::OFS_DUTY:   s_nxt.duty   = pwdata[W-1:0];
        pwq_pkg::OFS_PERIOD: s_nxt.period = pwdata[W-1:0];
        default: begin
        end
      endcase
    end
    if (upd_wr) begin
      s_nxt.pend_val = pwdata[W-1:0];
      if (imm_ok) begin
        // counter at 0 or 1 bypasses the deferral
        s_nxt.pend_valid = 1'b0;
        if (s_r.upd_period) begin
          s_nxt.period = pwdata[W-1:0];
        end else begin
          s_nxt.duty = pwdata[W-1:0];
        end
      end else if (!(s_r.upd_period && s_r.period == '0)) begin
        // held until the next period start
        s_nxt.pend_valid     = 1'b1;
        s_nxt.pend_is_period = s_r.upd_period;
      end
    end
    if (en_wr) begin
      s_nxt.enabled      = 1'b1;
      s_nxt.active_flag  = 1'b1;
      s_nxt.first_period = 1'b1;
      s_nxt.aged         = 1'b0;
      s_nxt.count_down   = 1'b0;
      s_nxt.presc        = '0;
      s_nxt.counter      = pwq_pkg::CNT_FIRST;
    end else if (dis_wr) begin
      // early disable leaves the flag standing
      s_nxt.enabled = 1'b0;
      s_nxt.presc   = '0;
      s_nxt.counter = '0;
      if (s_r.aged) begin
        s_nxt.active_flag = 1'b0;
      end
    end
    // zero duty never matches, level stays inactive
    s_nxt.wave = s_r.enabled && ((s_r.counter < s_r.duty) ? s_r.pol : !s_r.pol);
    s_nxt.rsp.pready  = psel && !penable;
    s_nxt.rsp.pslverr = psel && !penable && !is_mapped(paddr);
    s_nxt.rsp.prdata  = (psel && !penable && !pwrite) ? read_word(s_r, paddr) : 32'h00000000;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= pwq_pkg::RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata  = s_r.rsp.prdata;
  assign pready  = s_r.rsp.pready;
  assign pslverr = s_r.rsp.pslverr;
  assign pwm_out = s_r.wave;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  imm_duty_update_a: assert property (
    (upd_wr && s_r.counter <= pwq_pkg::CNT_IMM_MAX && !s_r.upd_period)
    |=> (s_r.duty == $past(pwdata[W-1:0])))
    else $error("duty not updated at once with counter at 0 or 1");

  zero_period_keep_a: assert property (
    (upd_wr && s_r.upd_period && s_r.period == '0 && !wr_period_direct())
    |=> (s_r.period == '0) && !s_r.pend_valid)
    else $error("period update taken while period was zero");

  first_start_a: assert property (
    en_wr |=> (s_r.counter == pwq_pkg::CNT_FIRST) && s_r.first_period)
    else $error("first period did not start from zero");

  later_start_a: assert property (
    (period_end && !s_r.center && !en_wr && !dis_wr)
    |=> (s_r.counter == pwq_pkg::CNT_LATER) && !s_r.first_period)
    else $error("later period did not start from one");

  zero_duty_flat_a: assert property (
    (s_r.enabled && s_r.duty == '0) |=> (pwm_out == !$past(s_r.pol)))
    else $error("zero duty produced a pulse");

  early_disable_a: assert property (
    (dis_wr && !s_r.aged && !en_wr) |=> s_r.active_flag && !s_r.enabled ##1 !pwm_out)
    else $error("early disable cleared flag or kept output");

  late_disable_a: assert property (
    (dis_wr && s_r.aged) |=> !s_r.active_flag && !s_r.enabled)
    else $error("disable after one clock period left flag set");

  deferred_duty_a: assert property (
    (upd_wr && !imm_ok && !s_r.upd_period && !period_end && !wr_duty_direct())
    |=> (s_r.duty == $past(s_r.duty)) && s_r.pend_valid && !s_r.pend_is_period)
    else $error("update applied before period boundary");

  boundary_apply_a: assert property (
    (period_end && s_r.pend_valid && !s_r.pend_is_period && !wr)
    |=> (s_r.duty == $past(s_r.pend_val)) && !s_r.pend_valid)
    else $error("pending duty not applied at period start");

  apb_answer_a: assert property (
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer not exactly one access cycle");

  apb_error_a: assert property (
    (psel && !penable && !is_mapped(paddr))
    |=> pready && pslverr && (prdata == 32'h00000000))
    else $error("unmapped address answered without error");

  apb_quiet_a: assert property (
    !pready |-> !pslverr && (prdata == 32'h00000000))
    else $error("bus answer outputs not idle outside access");

  imm_period_update_a: assert property (
    (upd_wr && s_r.counter <= pwq_pkg::CNT_IMM_MAX &&
     s_r.upd_period && s_r.period != '0)
    |=> (s_r.period == $past(pwdata[W-1:0])) && !s_r.pend_valid)
    else $error("period not updated at once with counter at 0 or 1");

  zero_period_idle_a: assert property (
    (tick && s_r.period == '0) |=> (s_r.counter == '0))
    else $error("counter moved while period was zero");

  left_step_a: assert property (
    (tick && !s_r.center && s_r.period != '0 &&
     !period_end && !en_wr && !dis_wr)
    |=> (s_r.counter == $past(s_r.counter) + 1'b1))
    else $error("left-aligned counter skipped a step");

  center_turn_a: assert property (
    (tick && s_r.center && s_r.count_down && s_r.counter <= pwq_pkg::CNT_LATER &&
     s_r.period != '0 && !en_wr && !dis_wr)
    |=> (s_r.counter == '0) && !s_r.count_down)
    else $error("center-aligned counter did not turn at the bottom");

  disabled_low_a: assert property (
    !s_r.enabled |=> !pwm_out)
    else $error("output active while channel disabled");

  enable_flag_a: assert property (
    en_wr |=> s_r.active_flag && s_r.enabled && !s_r.aged)
    else $error("enable did not set flag and restart aging");

  aging_tick_a: assert property (
    (tick && !en_wr) |=> s_r.aged)
    else $error("first selected-clock tick did not age channel");

  early_disable_c: cover property (en_wr ##1 (!tick)[*1] ##1 dis_wr);
  immediate_c:     cover property (upd_wr && imm_ok && s_r.enabled);
  deferred_c:      cover property ((upd_wr && !imm_ok) ##[1:300] (period_end && s_r.pend_valid));
  period_loop_c:   cover property (period_end && !s_r.center ##[1:300] period_end);
  zero_period_c:   cover property (upd_wr && s_r.upd_period && s_r.period == '0);

  function automatic logic wr_period_direct();
    wr_period_direct = wr && (paddr == pwq_pkg::OFS_PERIOD);
  endfunction

  function automatic logic wr_duty_direct();
    wr_duty_direct = wr && (paddr == pwq_pkg::OFS_DUTY);
  endfunction
endmodule

// >>> hw/pwq_pkg.sv
// Constants and carrier types for the pulse-width channel
package pwq_pkg;
  localparam int          CNT_W            = 16;
  localparam int          PRE_W            = 4;
  localparam int          PRESC_W          = 16;

  localparam logic [7:0]  OFS_ENABLE       = 8'h00;
  localparam logic [7:0]  OFS_DISABLE      = 8'h04;
  localparam logic [7:0]  OFS_STATUS       = 8'h08;
  localparam logic [7:0]  OFS_MODE         = 8'h0C;
  localparam logic [7:0]  OFS_DUTY         = 8'h10;
  localparam logic [7:0]  OFS_PERIOD       = 8'h14;
  localparam logic [7:0]  OFS_COUNTER      = 8'h18;
  localparam logic [7:0]  OFS_UPDATE       = 8'h1C;

  localparam int          CMD_BIT          = 0;
  localparam int          STS_ACTIVE_BIT   = 0;
  localparam int          STS_ENABLED_BIT  = 1;
  localparam int          STS_PEND_BIT     = 2;
  localparam int          MODE_POL_BIT     = 0;
  localparam int          MODE_UPD_PER_BIT = 1;
  localparam int          MODE_CENTER_BIT  = 2;
  localparam int          MODE_PRE_LSB     = 8;

  localparam logic [CNT_W-1:0] RST_PERIOD  = 16'h00FF;
  localparam logic [CNT_W-1:0] RST_DUTY    = 16'h0080;
  localparam logic [CNT_W-1:0] CNT_FIRST   = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_LATER   = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_IMM_MAX = 16'h0001;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pwq_apb_rsp_type;

  typedef struct packed {
    pwq_apb_rsp_type    rsp;
    logic               enabled;
    logic               active_flag;
    logic               first_period;
    logic               aged;
    logic               count_down;
    logic               pol;
    logic               upd_period;
    logic               center;
    logic [PRE_W-1:0]   pre;
    logic [PRESC_W-1:0] presc;
    logic [CNT_W-1:0]   period;
    logic [CNT_W-1:0]   duty;
    logic [CNT_W-1:0]   counter;
    logic [CNT_W-1:0]   pend_val;
    logic               pend_valid;
    logic               pend_is_period;
    logic               wave;
  } pwq_state_type;

  localparam pwq_state_type RST_STATE = '{period: RST_PERIOD, duty: RST_DUTY, default: '0};
endpackage

// >>> verification/pwq_channel_tb.sv
// Self-checking bench for the pulse-width channel over APB
module pwq_channel_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pwm_out;
  logic [31:0] rd_v;
  logic        err_v;
  int          num_errors;
  int          n_tests;
  int          rise[3];
  int          fall[3];
  int          nr;
  int          nf;
  int          ones;
  int          i;

  pwq_channel dut_u (
    .clk     (clk),
    .reset   (reset),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .pwm_out (pwm_out)
  );

  initial clk = 1'b0;
  always #2 clk = ~clk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; leaves the bus held for a back-to-back setup
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_v  = prdata;
    err_v = pslverr;
  endtask

  task idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle();
  endtask

  task rdv(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    idle();
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    rdv(a);
    chk(rd_v, exp);
  endtask

  // Cycle numbers of the first output edges
  task edges();
    logic prev;
    int   t;
    nr = 0;
    nf = 0;
    prev = pwm_out;
    for (t = 0; t < 40; t++) begin
      @(posedge clk);
      if (pwm_out === 1'b1 && prev === 1'b0 && nr < 3) begin
        rise[nr] = t;
        nr++;
      end
      if (pwm_out === 1'b0 && prev === 1'b1 && nf < 3) begin
        fall[nf] = t;
        nf++;
      end
      prev = pwm_out;
    end
  endtask

  task close_out();
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(30000 * 4);
    num_errors++;
    close_out();
  end

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    chk({29'h0, pready, pslverr, pwm_out}, 32'h0);
    reset <= 1'b0;
    @(posedge clk);
    rd(pwq_pkg::OFS_PERIOD, 32'h0000_00FF);
    rd(pwq_pkg::OFS_DUTY, 32'h0000_0080);
    rd(pwq_pkg::OFS_MODE, 32'h0);
    rd(pwq_pkg::OFS_STATUS, 32'h0);
    chk(err_v, 1'b0);
    wr(8'h20, 32'h5);
    chk(err_v, 1'b1);
    rd(8'h20, 32'h0);
    chk(err_v, 1'b1);
    wr(pwq_pkg::OFS_PERIOD, 32'h4);
    wr(pwq_pkg::OFS_DUTY, 32'h2);
    wr(pwq_pkg::OFS_MODE, 32'h1);
    wr(pwq_pkg::OFS_ENABLE, 32'h1);
    edges();
    chk(32'(nr), 32'h3);
    chk(32'(rise[1] - rise[0]), 32'h5);
    chk(32'(rise[2] - rise[1]), 32'h4);
    chk(32'(fall[0] - rise[0]), 32'h2);
    chk(32'(fall[1] - rise[1]), 32'h1);
    wr(pwq_pkg::OFS_DISABLE, 32'h1);
    rd(pwq_pkg::OFS_STATUS, 32'h0);
    wr(pwq_pkg::OFS_PERIOD, 32'h28);
    wr(pwq_pkg::OFS_DUTY, 32'h5);
    wr(pwq_pkg::OFS_ENABLE, 32'h1);
    for (i = 0; i < 60; i++) begin
      rdv(pwq_pkg::OFS_COUNTER);
      if (rd_v >= 32'h5 && rd_v <= 32'h14) break;
    end
    wr(pwq_pkg::OFS_UPDATE, 32'hC);
    rd(pwq_pkg::OFS_DUTY, 32'h5);
    rd(pwq_pkg::OFS_STATUS, 32'h7);
    for (i = 0; i < 40; i++) begin
      rdv(pwq_pkg::OFS_STATUS);
      if (rd_v[2] === 1'b0) break;
    end
    rd(pwq_pkg::OFS_DUTY, 32'hC);
    apb(1'b1, pwq_pkg::OFS_ENABLE, 32'h1);
    apb(1'b1, pwq_pkg::OFS_UPDATE, 32'h9);
    idle();
    rd(pwq_pkg::OFS_DUTY, 32'h9);
    rd(pwq_pkg::OFS_STATUS, 32'h3);
    wr(pwq_pkg::OFS_MODE, 32'h2);
    apb(1'b1, pwq_pkg::OFS_ENABLE, 32'h1);
    apb(1'b1, pwq_pkg::OFS_UPDATE, 32'h6);
    idle();
    rd(pwq_pkg::OFS_PERIOD, 32'h6);
    wr(pwq_pkg::OFS_PERIOD, 32'h0);
    wr(pwq_pkg::OFS_UPDATE, 32'hA);
    rd(pwq_pkg::OFS_PERIOD, 32'h0);
    rd(pwq_pkg::OFS_STATUS, 32'h3);
    wr(pwq_pkg::OFS_MODE, 32'h0);
    wr(pwq_pkg::OFS_PERIOD, 32'h4);
    wr(pwq_pkg::OFS_DUTY, 32'h0);
    repeat (4) @(posedge clk);
    ones = 0;
    repeat (16) begin
      @(posedge clk);
      if (pwm_out === 1'b1) ones++;
    end
    chk(32'(ones), 32'h10);
    wr(pwq_pkg::OFS_DISABLE, 32'h1);
    wr(pwq_pkg::OFS_MODE, 32'h300);
    apb(1'b1, pwq_pkg::OFS_ENABLE, 32'h1);
    apb(1'b1, pwq_pkg::OFS_DISABLE, 32'h1);
    idle();
    rd(pwq_pkg::OFS_STATUS, 32'h1);
    chk(pwm_out, 1'b0);
    wr(pwq_pkg::OFS_ENABLE, 32'h1);
    repeat (20) @(posedge clk);
    wr(pwq_pkg::OFS_DISABLE, 32'h1);
    rd(pwq_pkg::OFS_STATUS, 32'h0);
    // Center-aligned: up to period and back down
    wr(pwq_pkg::OFS_MODE, 32'h4);
    wr(pwq_pkg::OFS_PERIOD, 32'h4);
    wr(pwq_pkg::OFS_DUTY, 32'h2);
    wr(pwq_pkg::OFS_ENABLE, 32'h1);
    edges();
    chk(32'(rise[1] - rise[0]), 32'h8);
    chk(32'(fall[0] - rise[0]), 32'h5);
    close_out();
  end
endmodule
